// ### hdl/ddff_top.v
/*
  Two independent edge-triggered storage elements with active-low set and
  clear, each with its own element clock, data pin and output pair.
  Assumes every pin input is asynchronous to core_clk and that element clocks
  are far slower than core_clk, so their edges are seen by sampling.
*/
`timescale 1ns/1ps
`include "ddff_consts.vh"
module ddff_top (
  input  wire core_clk,
  input  wire rst,
  input  wire a_clk,
  input  wire a_data,
  input  wire a_async_set_n,
  input  wire a_async_clear_n,
  output wire a_q,
  output wire a_q_n,
  input  wire b_clk,
  input  wire b_data,
  input  wire b_async_set_n,
  input  wire b_async_clear_n,
  output wire b_q,
  output wire b_q_n
);

  localparam NUM = 2;

  wire [`DDFF_PIN_W*NUM-1:0] pins_raw;
  wire [NUM-1:0]             q_vec;
  wire [NUM-1:0]             q_n_vec;

  assign pins_raw = {b_clk, b_data, b_async_set_n, b_async_clear_n,
                     a_clk, a_data, a_async_set_n, a_async_clear_n};

  // one-hot control modes of one element
  localparam [3:0] MODE_HOLD  = 4'h1;
  localparam [3:0] MODE_SET   = 4'h2;
  localparam [3:0] MODE_CLEAR = 4'h4;
  localparam [3:0] MODE_BOTH  = 4'h8;

  // active-low set and clear pair to a one-hot mode
  function [3:0] ctrl_mode;
    input set_in_n;
    input clr_in_n;
    begin
      case ({set_in_n, clr_in_n})
        2'h0: begin
          ctrl_mode = MODE_BOTH;
        end
        2'h1: begin
          ctrl_mode = MODE_SET;
        end
        2'h2: begin
          ctrl_mode = MODE_CLEAR;
        end
        default: begin
          ctrl_mode = MODE_HOLD;
        end
      endcase
    end
  endfunction

  // next stored value of one element
  function store_next;
    input [3:0] mode;
    input       load;
    input       data;
    input       store;
    begin
      case (mode)
        MODE_SET: begin
          store_next = 1'h1;
        end
        MODE_CLEAR: begin
          store_next = 1'h0;
        end
        MODE_HOLD: begin
          if (load) begin
            store_next = data;
          end else begin
            store_next = store;
          end
        end
        default: begin
          store_next = store;
        end
      endcase
    end
  endfunction

  // next output pair {true, inverted} of one element
  function [1:0] out_pair;
    input [3:0] mode;
    input       load;
    input       data;
    input       store;
    begin
      case (mode)
        MODE_BOTH: begin
          out_pair = 2'h3;
        end
        MODE_SET: begin
          out_pair = 2'h2;
        end
        MODE_CLEAR: begin
          out_pair = 2'h1;
        end
        MODE_HOLD: begin
          if (load) begin
            out_pair = {data, ~data};
          end else begin
            out_pair = {store, ~store};
          end
        end
        default: begin
          out_pair = {store, ~store};
        end
      endcase
    end
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < NUM; gi = gi + 1) begin : g_elem
      wire [`DDFF_PIN_W-1:0] pin_s;
      wire                   clk_s;
      wire                   data_s;
      wire                   set_n;
      wire                   clr_n;
      wire                   rise;
      wire [3:0]             mode;
      wire [1:0]             pair;
      reg                    clk_prev_ff;
      reg                    store_ff;
      reg                    q_ff;
      reg                    q_n_ff;
      reg                    nxt_clk_prev;
      reg                    nxt_store;
      reg                    nxt_q;
      reg                    nxt_q_n;

      ddff_sync #(
        .W       (`DDFF_PIN_W),
        .RST_VAL (`DDFF_PIN_RST)
      ) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_in   (pins_raw[gi*`DDFF_PIN_W +: `DDFF_PIN_W]),
        .pin_sync (pin_s)
      );

      assign clk_s  = pin_s[`DDFF_POS_CLK];
      assign data_s = pin_s[`DDFF_POS_DATA];
      assign set_n  = pin_s[`DDFF_POS_SET];
      assign clr_n  = pin_s[`DDFF_POS_CLR];

      assign rise = clk_s & ~clk_prev_ff;
      assign mode = ctrl_mode(set_n, clr_n);
      assign pair = out_pair(mode, rise, data_s, store_ff);

      always @* begin
        nxt_clk_prev = clk_s;
        nxt_store    = store_next(mode, rise, data_s, store_ff);
        nxt_q        = pair[1];
        nxt_q_n      = pair[0];
      end

      // preset high: a pin clock already high at release is no edge
      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          clk_prev_ff <= 1'h1;
        end else begin
          clk_prev_ff <= nxt_clk_prev;
        end
      end

      // stored bit, kept apart from the pair so both-low leaves it intact
      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          store_ff <= `DDFF_RST_STORE;
        end else begin
          store_ff <= nxt_store;
        end
      end

      // registered output pair
      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          q_ff   <= `DDFF_RST_STORE;
          q_n_ff <= ~`DDFF_RST_STORE;
        end else begin
          q_ff   <= nxt_q;
          q_n_ff <= nxt_q_n;
        end
      end

      assign q_vec[gi]   = q_ff;
      assign q_n_vec[gi] = q_n_ff;
    end
  endgenerate

  assign a_q   = q_vec[0];
  assign a_q_n = q_n_vec[0];
  assign b_q   = q_vec[1];
  assign b_q_n = q_n_vec[1];

endmodule // ddff_top

// ### hdl/ddff_consts.vh
/*
  Constants for the dual storage element block: reset values, synchroniser
  reset patterns and field positions inside the synchronised pin bundle.
  Assumes it is included by bare name from files under hdl/.
*/
// How it works
// - two elements, nothing shared between them
// - set low alone: true high, inverted low
// - clear low alone: true low, inverted high
// - both low: both outputs high, not kept
// - both inactive: rising clock loads data
// - data ignored between rising clock edges
`ifndef DDFF_CONSTS_VH
`define DDFF_CONSTS_VH

// stored value after rst
`define DDFF_RST_STORE   1'h0
// pin bundle width and field positions
`define DDFF_PIN_W       4
`define DDFF_POS_CLR     0
`define DDFF_POS_SET     1
`define DDFF_POS_DATA    2
`define DDFF_POS_CLK     3
// synchroniser reset: clock high, data low, set and clear inactive
`define DDFF_PIN_RST     4'hB

`endif

// ### hdl/ddff_sync.v
/*
  Two-flop synchroniser for a bundle of asynchronous pin levels.
  Assumes inputs change without regard to core_clk; the first stage is read
  by the second stage only.
*/
`timescale 1ns/1ps
module ddff_sync #(
  parameter       W       = 4,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input  wire         core_clk,
  input  wire         rst,
  input  wire [W-1:0] pin_in,
  output wire [W-1:0] pin_sync
);

  reg [W-1:0] stage1_ff;
  reg [W-1:0] stage2_ff;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stage1_ff <= RST_VAL;
      stage2_ff <= RST_VAL;
    end else begin
      stage1_ff <= pin_in;
      stage2_ff <= stage1_ff;
    end
  end

  assign pin_sync = stage2_ff;

endmodule // ddff_sync

// ### testbench/ddff_props.sv
/* ddff_top pin checker; bound to every ddff_top, one core_clk domain */
`timescale 1ns/1ps
module ddff_props (input wire core_clk, rst, a_clk, a_data, a_async_set_n,
  a_async_clear_n, a_q, a_q_n, b_clk, b_data, b_async_set_n,
  b_async_clear_n, b_q, b_q_n);
  wire sa = !a_async_set_n, ca = !a_async_clear_n, ra = !sa && !ca;
  wire rb = b_async_set_n && b_async_clear_n;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_set; (sa && !ca)[*4] |-> a_q && !a_q_n; endproperty
  a_set: assert property (p_set) else $error("set");
  property p_clear; (ca && !sa)[*4] |-> !a_q && a_q_n; endproperty
  a_clear: assert property (p_clear) else $error("clear");
  property p_both; (sa && ca)[*4] |-> a_q && a_q_n; endproperty
  a_both: assert property (p_both) else $error("both");
  property p_load; $rose(a_clk) && ra ##1 ra[*2] |=>
    a_q == $past(a_data, 3) && a_q_n != a_q; endproperty
  a_load: assert property (p_load) else $error("load");
  property p_keep; $rose(a_clk) && ra ##1 (ra && !$rose(a_clk))[*8] |->
    a_q == $past(a_data, 8); endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_hold; (ra && !$rose(a_clk))[*5] |-> $stable({a_q, a_q_n});
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_b_hold; (rb && !$rose(b_clk))[*5] |-> $stable({b_q, b_q_n});
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("b hold");
endmodule // ddff_props
bind ddff_top ddff_props ddff_props_inst (.*);

// ### testbench/ddff_pins.sv
/* pin levels for both elements; want is changed away from falling edges */
`timescale 1ns/1ps
module ddff_pins (input wire core_clk, input wire [7:0] want,
  output reg [7:0] pins);
  initial pins = 8'h33;
  always @(negedge core_clk) pins <= want;
endmodule // ddff_pins

// ### testbench/test_dual_d_flip_flop_set_clear.sv
/* bench for ddff_top; pins pass through ddff_pins */
`timescale 1ns/1ps
module test_dual_d_flip_flop_set_clear;
  reg        core_clk = 0;
  reg        rst = 1;
  reg  [7:0] want = 8'h33;
  wire [7:0] p;
  wire [3:0] q;
  integer    fails = 0;
  integer    checked = 0;
  ddff_pins ddff_pins_inst (.core_clk(core_clk), .want(want), .pins(p));
  ddff_top ddff_top_inst (.core_clk(core_clk), .rst(rst), .a_clk(p[7]),
    .a_data(p[6]), .a_async_set_n(p[5]), .a_async_clear_n(p[4]),
    .a_q(q[3]), .a_q_n(q[2]), .b_clk(p[3]), .b_data(p[2]),
    .b_async_set_n(p[1]), .b_async_clear_n(p[0]), .b_q(q[1]), .b_q_n(q[0]));
  initial forever #2.5 core_clk = ~core_clk;
  task go(input [7:0] w, input [3:0] e);
    want = w;
    repeat (4) @(posedge core_clk);
    #1 checked = checked + 1;
    if (q !== e) begin
      fails = fails + 1;
      $display("FAIL q exp %h got %h", e, q);
    end
  endtask
  task t_load;
    go(8'h73, 4'h5);
    go(8'hF3, 4'h9);
    go(8'hB3, 4'h9);
    go(8'h37, 4'h9);
    go(8'h3F, 4'hA);
    $display("load end");
  endtask
  task t_async;
    go(8'h2F, 4'h6);
    go(8'hEF, 4'h6);
    go(8'hFF, 4'h6);
    go(8'h0F, 4'hE);
    go(8'h1F, 4'hA);
    go(8'h3F, 4'hA);
    go(8'h3E, 4'h9);
    go(8'h2D, 4'h6);
    go(8'h0D, 4'hE);
    go(8'h3F, 4'h6);
    $display("async end");
  endtask
  task final_report;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    @(negedge core_clk) rst = 0;
    @(posedge core_clk);
    #1 t_load;
    t_async;
    final_report;
  end
endmodule // test_dual_d_flip_flop_set_clear
